// *** shared/pcfe_pkg.sv ***
// Purpose: constants and types for the checksummed command front end
// Assumes: 8-bit characters, 32-bit AXI4-Lite register bus
// Notes: all codes, offsets and fields are named here once
package pcfe_pkg;
  localparam logic [7:0] ACK_CODE = 8'h06;
  localparam logic [7:0] NAK_CODE = 8'h15;
  localparam logic [7:0] LF_CODE = 8'h0A;
  localparam logic [7:0] CR_CODE = 8'h0D;
  localparam logic [7:0] GLOBAL_CODE = 8'h2A;
  localparam logic [7:0] SEAL_BIT = 8'h80;
  localparam logic [7:0] LOW7_MASK = 8'h7F;
  localparam logic [7:0] NAME_RST = 8'h41;
  // Body text that leaves addressed mode
  localparam logic [31:0] LEAVE_TEXT = 32'h50593D30;
  localparam logic [2:0] LEAVE_LEN = 3'h4;
  localparam logic [2:0] POS_MAX = 3'h7;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_NAME = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam int CTRL_CHECK = 0;
  localparam int CTRL_ADDR = 1;
  localparam int CTRL_ECHO_LSB = 2;
  localparam int STAT_CS_LSB = 8;
  localparam logic [1:0] ECHO_RST = 2'h0;
  localparam logic [1:0] ECHO_SILENT = 2'h2;
  localparam int IRQ_ACC = 0;
  localparam int IRQ_REJ = 1;
  localparam int IRQ_MODE = 2;
  localparam int IRQ_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pcfe_char_t;
  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_BODY = 2'b01,
    ST_SKIP = 2'b10
  } pcfe_state_t;
endpackage

// *** verification/pcfe_frontend_asserts.sv ***
// Purpose: port-level checks of the command front end
// Assumes: one clock, synchronous active-low reset
// Notes: answer latencies are the designer's figures
`timescale 1ns/1ps
`default_nettype none
module pcfe_frontend_asserts (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B response
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire pcfe_pkg::pcfe_char_t rx_char, // Line in
  input wire pcfe_pkg::pcfe_char_t cmd_char, // Body out
  input wire logic cmd_end, // Line end
  input wire logic cmd_ok, // Accepted
  input wire pcfe_pkg::pcfe_char_t tx_char, // Line out
  input wire logic tx_ready // Line out taken
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_end_seen;
    cmd_end ##1 !cmd_end;
  endsequence
  property p_wr_answer;
    s_wr_taken |-> ##2 s_axi_bvalid;
  endproperty
  property p_aw_block;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_tx_hold;
    tx_char.valid && !tx_ready |=> tx_char.valid && $stable(tx_char.data);
  endproperty
  property p_ok_end;
    cmd_ok |-> cmd_end;
  endproperty
  property p_end_term;
    cmd_end |-> $past(rx_char.valid) && ($past(rx_char.data) == pcfe_pkg::LF_CODE
      || $past(rx_char.data) == pcfe_pkg::CR_CODE);
  endproperty
  property p_end_pulse;
    cmd_end |-> s_end_seen;
  endproperty
  property p_body_cause;
    cmd_char.valid |-> $past(rx_char.valid);
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no write response");
  a_aw_block: assert property (p_aw_block) else $error("address ready stayed high");
  a_rd_answer: assert property (p_rd_answer) else $error("no read data");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_tx_hold: assert property (p_tx_hold) else $error("tx char not held");
  a_ok_end: assert property (p_ok_end) else $error("accept without end");
  a_end_term: assert property (p_end_term) else $error("end without terminator");
  a_end_pulse: assert property (p_end_pulse) else $error("end not a pulse");
  a_body_cause: assert property (p_body_cause) else $error("body char uncaused");
endmodule
`default_nettype wire

// *** verification/pcfe_host_model.sv ***
// Purpose: host on the shared line, sends lines and takes answers
// Assumes: device samples rx_char on every edge
// Notes: idle data inverts so a stale byte never reads as fresh
`timescale 1ns/1ps
`default_nettype none
module pcfe_host_model (
  input wire logic aclk, // Clock
  input wire logic slow, // Accept only every fourth cycle
  input wire pcfe_pkg::pcfe_char_t tx_char, // From device
  output logic tx_ready, // Taking tx_char
  output pcfe_pkg::pcfe_char_t rx_char // To device
);
  logic [7:0] got[$];
  logic [1:0] ph = 2'h0;
  initial
  begin
    rx_char = '0;
    tx_ready = 1'b0;
  end
  // Only collects, never answers back
  always @(posedge aclk)
  begin
    if (tx_char.valid && tx_ready)
      got.push_back(tx_char.data);
    ph <= ph + 2'h1;
    tx_ready <= !slow || ph == 2'h3;
  end
  task automatic send(input logic [7:0] c);
    @(posedge aclk);
    rx_char <= {1'b1, c};
    @(posedge aclk);
    rx_char <= {1'b0, ~c};
  endtask
endmodule
`default_nettype wire

// *** verification/tb_pcfe_frontend.sv ***
// Purpose: self-checking bench for the command front end
// Assumes: host model drives the line, bench drives AXI and replies
// Notes: settle waits cover the two-cycle answer latency
`timescale 1ns/1ps
`default_nettype none
module tb_pcfe_frontend;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  pcfe_pkg::pcfe_char_t rx_char, cmd_char, tx_char;
  pcfe_pkg::pcfe_char_t reply_char = '0;
  logic reply_last = 1'b0, slow = 1'b0;
  logic cmd_end, cmd_ok, reply_ready, tx_ready, irq;
  int mismatches = 0, checks = 0, cyc = 0, ends = 0;
  logic last_ok = 1'b0;
  logic [7:0] cq[$];
  always #25 aclk = ~aclk;
  pcfe_frontend dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_char, .cmd_char, .cmd_end, .cmd_ok, .reply_char,
    .reply_last, .reply_ready, .tx_char, .tx_ready, .irq);
  pcfe_host_model hm (.aclk, .slow, .tx_char, .tx_ready, .rx_char);
  always @(posedge aclk)
  begin
    cyc++;
    if (cmd_char.valid)
      cq.push_back(cmd_char.data);
    if (cmd_end)
    begin
      ends++;
      last_ok = cmd_ok;
    end
    if (cyc == 6000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      r = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(32'(r), 32'(er));
    if (er == pcfe_pkg::RESP_OKAY)
      chk(d, e);
  endtask
  function automatic logic [7:0] seal(input logic [7:0] sum);
    return ((~sum) + 8'h01) | 8'h80;
  endfunction
  task automatic line(input string s, input logic bad);
    logic [7:0] sum;
    sum = 8'h00;
    foreach (s[i])
    begin
      hm.send(s[i]);
      sum += s[i];
    end
    hm.send(seal(sum) ^ {7'h00, bad});
    hm.send(pcfe_pkg::LF_CODE);
    repeat (12) @(posedge aclk);
  endtask
  task automatic reply(input logic [7:0] c);
    @(posedge aclk);
    reply_char <= {1'b1, c};
    reply_last <= 1'b1;
    do
      @(posedge aclk);
    while (!reply_ready);
    reply_char <= {1'b0, ~c};
    reply_last <= 1'b0;
    repeat (30) @(posedge aclk);
  endtask
  task automatic body(input string s);
    chk(32'(cq.size()), 32'(s.len() - 1));
    for (int i = 1; i < s.len(); i++)
      if (cq.size() != 0)
        chk(32'(cq.pop_front()), 32'(s[i]));
    cq.delete();
  endtask
  task automatic tx1(input logic [7:0] e);
    chk(32'(hm.got.size() != 0), 32'h1);
    if (hm.got.size() != 0)
      chk(32'(hm.got.pop_front()), 32'(e));
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(pcfe_pkg::REG_CTRL, 32'h0, pcfe_pkg::RESP_OKAY);
    rdc(pcfe_pkg::REG_NAME, 32'h41, pcfe_pkg::RESP_OKAY);
    rdc(pcfe_pkg::REG_IRQ_STAT, 32'h0, pcfe_pkg::RESP_OKAY);
    rdc(8'h14, 32'h0, pcfe_pkg::RESP_SLVERR);
    wr(8'h14, 32'h0, pcfe_pkg::RESP_SLVERR);
    wr(pcfe_pkg::REG_IRQ_MASK, 32'h7, pcfe_pkg::RESP_OKAY);
    wr(pcfe_pkg::REG_CTRL, 32'h1, pcfe_pkg::RESP_OKAY);
    hm.send(pcfe_pkg::LF_CODE);
    repeat (4) @(posedge aclk);
    rdc(pcfe_pkg::REG_CTRL, 32'h3, pcfe_pkg::RESP_OKAY);
    chk(32'(irq), 32'h1);
    wr(pcfe_pkg::REG_IRQ_MASK, 32'h0, pcfe_pkg::RESP_OKAY);
    chk(32'(irq), 32'h0);
    wr(pcfe_pkg::REG_IRQ_MASK, 32'h7, pcfe_pkg::RESP_OKAY);
    wr(pcfe_pkg::REG_IRQ_STAT, 32'h4, pcfe_pkg::RESP_OKAY);
    chk(32'(irq), 32'h0);
    line("AMR 1", 1'b0);
    body("AMR 1");
    chk(32'(ends), 32'h1);
    chk(32'(last_ok), 32'h1);
    tx1(pcfe_pkg::ACK_CODE);
    slow <= 1'b1;
    line("AMR 1", 1'b1);
    cq.delete();
    chk(32'(last_ok), 32'h0);
    tx1(pcfe_pkg::NAK_CODE);
    rdc(pcfe_pkg::REG_STATUS, 32'h0000FF00, pcfe_pkg::RESP_OKAY);
    line("aMR 1", 1'b0);
    chk(32'(ends), 32'h2);
    chk(32'(cq.size() + hm.got.size()), 32'h0);
    line("APR P", 1'b0);
    cq.delete();
    reply(8'h58);
    tx1(pcfe_pkg::ACK_CODE);
    tx1(8'h58);
    tx1(seal(8'h58));
    line("*MV 1", 1'b0);
    reply(8'h59);
    body("*MV 1");
    chk(32'(ends), 32'h4);
    chk(32'(hm.got.size()), 32'h0);
    wr(pcfe_pkg::REG_CTRL, 32'hB, pcfe_pkg::RESP_OKAY);
    line("AMV 2", 1'b0);
    body("AMV 2");
    chk(32'(hm.got.size()), 32'h0);
    wr(pcfe_pkg::REG_CTRL, 32'h3, pcfe_pkg::RESP_OKAY);
    line("APY=0", 1'b0);
    rdc(pcfe_pkg::REG_CTRL, 32'h1, pcfe_pkg::RESP_OKAY);
    hm.send(pcfe_pkg::LF_CODE);
    line({"*P", "Y=0"}, 1'b0);
    rdc(pcfe_pkg::REG_CTRL, 32'h1, pcfe_pkg::RESP_OKAY);
    rdc(pcfe_pkg::REG_IRQ_STAT, 32'h7, pcfe_pkg::RESP_OKAY);
    wr(pcfe_pkg::REG_IRQ_STAT, 32'h7, pcfe_pkg::RESP_OKAY);
    chk(32'(irq), 32'h0);
    tally_and_finish();
  end
endmodule
bind pcfe_frontend pcfe_frontend_asserts chk_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_char,
  .cmd_char, .cmd_end, .cmd_ok, .tx_char, .tx_ready);
`default_nettype wire

// *** verilog/pcfe_frontend.sv ***
// Purpose: checksummed, addressed command line front end
// Assumes: one rx character per valid cycle; interpreter replies after cmd_end
// Notes: AXI4-Lite control, sticky interrupts, one-character holdback
// What this block does
// - checksum is negated sum with bit 7 set
// - running checksum clears per command, adds characters
// - terminator with checking tests low seven bits
// - nonzero low bits: discard command, send NAK
// - zero low bits: accept, send ACK instead
// - compare own name case-sensitively with prefix
// - first line feed at a line start turns addressed mode on
// - asterisk prefix: all execute, none reply
// - mode-off command, named or global, leaves addressed mode
// - in addressed mode only the named unit sends print replies
// - ACK is 06h, NAK is 15h
// - checksum covers name and body, not terminator
// - line feed ends addressed lines, else CR
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pcfe_frontend #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk, // Clock, 20 MHz
  input wire logic aresetn, // Sync reset, low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire pcfe_pkg::pcfe_char_t rx_char, // Received character
  output pcfe_pkg::pcfe_char_t cmd_char, // Command body character
  output logic cmd_end, // Line finished, pulse
  output logic cmd_ok, // Line accepted, with cmd_end
  input wire pcfe_pkg::pcfe_char_t reply_char, // Reply character
  input wire logic reply_last, // Last reply character
  output logic reply_ready, // Reply character taken
  output pcfe_pkg::pcfe_char_t tx_char, // Character to send
  input wire logic tx_ready, // Transmitter takes tx_char
  output logic irq // Interrupt, level
);
  function automatic logic [7:0] seal(input logic [7:0] s);
    seal = (~s + 8'h01) | pcfe_pkg::SEAL_BIT;
  endfunction

  function automatic logic [7:0] leave_char(input logic [2:0] p);
    leave_char = pcfe_pkg::LEAVE_TEXT[8'(31 - 8 * int'(p)) -: 8];
  endfunction

  // Registers
  logic line_check_enable;
  logic addressed_mode_sel;
  logic [1:0] echo_behaviour_sel;
  logic [7:0] unit_name;
  logic [pcfe_pkg::IRQ_W-1:0] irq_stat;
  logic [pcfe_pkg::IRQ_W-1:0] irq_mask;

  // Bus state
  logic aw_got;
  logic w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Line state
  pcfe_pkg::pcfe_state_t state;
  pcfe_pkg::pcfe_state_t next_state;
  logic global_line;
  logic held_valid;
  logic [7:0] held;
  logic [2:0] lv_pos;
  logic lv_bad;

  // Transmit state
  logic ack_pend;
  logic [7:0] ack_code;
  logic reply_allow;
  logic cs_pend;
  logic [7:0] cs_code;

  // Checksum wires
  logic [7:0] rx_sum;
  logic [7:0] tx_sum;
  logic [7:0] tx_sum_next;

  // Bus decode
  wire do_wr;
  wire [7:0] wr_off;
  wire [7:0] rd_off;
  wire wr_hit;
  wire rd_hit;
  wire wr_ctrl;
  wire wr_name;
  wire wr_stat;
  wire wr_mask;
  wire lane0;
  wire [31:0] rd_mux;
  wire ar_take;

  assign do_wr = aw_got && w_got && !s_axi_bvalid;
  assign wr_off = 8'(aw_addr);
  assign rd_off = 8'(s_axi_araddr);
  assign lane0 = w_strb[0];
  assign wr_ctrl = do_wr && lane0 && (wr_off == pcfe_pkg::REG_CTRL);
  assign wr_name = do_wr && lane0 && (wr_off == pcfe_pkg::REG_NAME);
  assign wr_stat = do_wr && lane0 && (wr_off == pcfe_pkg::REG_IRQ_STAT);
  assign wr_mask = do_wr && lane0 && (wr_off == pcfe_pkg::REG_IRQ_MASK);
  assign wr_hit = (wr_off == pcfe_pkg::REG_CTRL) || (wr_off == pcfe_pkg::REG_NAME)
    || (wr_off == pcfe_pkg::REG_STATUS) || (wr_off == pcfe_pkg::REG_IRQ_STAT)
    || (wr_off == pcfe_pkg::REG_IRQ_MASK);
  assign rd_hit = (rd_off == pcfe_pkg::REG_CTRL) || (rd_off == pcfe_pkg::REG_NAME)
    || (rd_off == pcfe_pkg::REG_STATUS) || (rd_off == pcfe_pkg::REG_IRQ_STAT)
    || (rd_off == pcfe_pkg::REG_IRQ_MASK);
  assign s_axi_awready = !aw_got;
  assign s_axi_wready = !w_got;
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_mux =
    (rd_off == pcfe_pkg::REG_CTRL) ? {28'h0000000, echo_behaviour_sel,
      addressed_mode_sel, line_check_enable} :
    (rd_off == pcfe_pkg::REG_NAME) ? {24'h000000, unit_name} :
    (rd_off == pcfe_pkg::REG_STATUS) ? {16'h0000, rx_sum, 6'h00, state} :
    (rd_off == pcfe_pkg::REG_IRQ_STAT) ? {29'h00000000, irq_stat} :
    (rd_off == pcfe_pkg::REG_IRQ_MASK) ? {29'h00000000, irq_mask} :
    32'h00000000;

  // Receive decode
  wire rx_take;
  wire [7:0] rx_d;
  wire is_lf;
  wire is_cr;
  wire is_term;
  wire at_start;
  wire lf_activate;
  wire name_own;
  wire name_all;
  wire body_char;
  wire finish;
  wire line_ok;
  wire lv_hit;
  wire lv_clear;
  wire rx_clear;
  wire rx_add;
  wire fwd_held;
  wire send_answer;

  assign rx_take = rx_char.valid;
  assign rx_d = rx_char.data;
  assign is_lf = rx_d == pcfe_pkg::LF_CODE;
  assign is_cr = rx_d == pcfe_pkg::CR_CODE;
  assign is_term = addressed_mode_sel ? is_lf : is_cr;
  assign at_start = state == pcfe_pkg::ST_START;
  assign lf_activate = rx_take && at_start && !addressed_mode_sel && is_lf;
  assign name_own = rx_d == unit_name;
  assign name_all = rx_d == pcfe_pkg::GLOBAL_CODE;
  assign body_char = rx_take && (state == pcfe_pkg::ST_BODY) && !is_term;
  assign finish = rx_take && (state == pcfe_pkg::ST_BODY) && is_term;
  // Low seven bits only, bit 7 being the sender's seal
  assign line_ok = !line_check_enable
    || ((rx_sum & pcfe_pkg::LOW7_MASK) == 8'h00);
  assign lv_hit = !lv_bad && (lv_pos == (pcfe_pkg::LEAVE_LEN
    + 3'(line_check_enable)));
  assign lv_clear = finish && line_ok && lv_hit && addressed_mode_sel;
  // Start of line loads the first counted character; terminator never added
  assign rx_clear = rx_take && at_start;
  assign rx_add = rx_take && !is_term && !(at_start && !addressed_mode_sel && is_lf)
    && (state != pcfe_pkg::ST_SKIP);
  // Held character is the checksum when checking, so it is dropped
  assign fwd_held = held_valid && (body_char || (finish && !line_check_enable));
  assign send_answer = finish && line_check_enable && !global_line
    && (echo_behaviour_sel != pcfe_pkg::ECHO_SILENT);

  always_comb
  begin
    next_state = state;
    case (state)
      pcfe_pkg::ST_START:
      begin
        if (rx_take && !is_term && !is_lf)
        begin
          if (!addressed_mode_sel || name_own || name_all)
            next_state = pcfe_pkg::ST_BODY;
          else
            next_state = pcfe_pkg::ST_SKIP;
        end
      end
      pcfe_pkg::ST_BODY:
      begin
        if (rx_take && is_term)
          next_state = pcfe_pkg::ST_START;
      end
      pcfe_pkg::ST_SKIP:
      begin
        if (rx_take && is_term)
          next_state = pcfe_pkg::ST_START;
      end
      default:
        next_state = pcfe_pkg::ST_START;
    endcase
  end

  pcfe_sum u_rx_sum (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(rx_clear),
    .add(rx_add),
    .din(rx_d),
    .sum(rx_sum),
    .sum_next()
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= pcfe_pkg::ST_START;
    else
      state <= next_state;
  end

  // Name prefix decides who the line is for
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      global_line <= 1'b0;
    else if (rx_take && at_start)
      global_line <= addressed_mode_sel && name_all;
  end

  // One-character holdback hides the checksum from the interpreter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      held_valid <= 1'b0;
    else if (finish || (rx_take && at_start && addressed_mode_sel))
      held_valid <= 1'b0;
    else if (body_char || (rx_take && at_start && !is_cr && !is_lf))
      held_valid <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      held <= 8'h00;
    else if (body_char || (rx_take && at_start))
      held <= rx_d;
  end

  // Matcher for the body text that leaves addressed mode
  wire lv_first;
  wire lv_step;
  assign lv_first = rx_take && at_start && !addressed_mode_sel && !is_cr && !is_lf;
  assign lv_step = body_char || lv_first;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lv_pos <= 3'h0;
      lv_bad <= 1'b0;
    end
    else if (rx_take && at_start && !lv_first)
    begin
      lv_pos <= 3'h0;
      lv_bad <= 1'b0;
    end
    else if (lv_step)
    begin
      if (lv_pos != pcfe_pkg::POS_MAX)
        lv_pos <= lv_pos + 3'h1;
      if (lv_pos < pcfe_pkg::LEAVE_LEN && rx_d != leave_char(lv_pos))
        lv_bad <= 1'b1;
      if (lv_first)
      begin
        lv_pos <= 3'h1;
        lv_bad <= rx_d != leave_char(3'h0);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_char <= '0;
      cmd_end <= 1'b0;
      cmd_ok <= 1'b0;
    end
    else
    begin
      cmd_char.valid <= fwd_held;
      cmd_char.data <= held;
      cmd_end <= finish;
      cmd_ok <= finish && line_ok;
    end
  end

  // Transmit path: answer code, then reply, then reply checksum
  wire tx_free;
  wire ack_send;
  wire cs_send;
  wire rep_take;
  wire rep_drop;
  assign tx_free = !tx_char.valid || tx_ready;
  assign ack_send = tx_free && ack_pend;
  assign cs_send = tx_free && !ack_pend && cs_pend;
  assign rep_take = reply_char.valid && reply_allow && tx_free && !ack_pend && !cs_pend;
  assign rep_drop = reply_char.valid && !reply_allow;
  assign reply_ready = !reply_allow || (tx_free && !ack_pend && !cs_pend);

  pcfe_sum u_tx_sum (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(rep_take && reply_last),
    .add(rep_take && !reply_last),
    .din(reply_char.data),
    .sum(tx_sum),
    .sum_next(tx_sum_next)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ack_pend <= 1'b0;
      ack_code <= pcfe_pkg::ACK_CODE;
    end
    else if (send_answer)
    begin
      ack_pend <= 1'b1;
      ack_code <= line_ok ? pcfe_pkg::ACK_CODE : pcfe_pkg::NAK_CODE;
    end
    else if (ack_send)
      ack_pend <= 1'b0;
  end

  // Replies only for an accepted line that named this unit alone or came outside addressed mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reply_allow <= 1'b0;
    else if (finish)
      reply_allow <= line_ok && !global_line;
    else if ((rep_take || rep_drop) && reply_last)
      reply_allow <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cs_pend <= 1'b0;
      cs_code <= 8'h00;
    end
    else if (rep_take && reply_last && line_check_enable)
    begin
      cs_pend <= 1'b1;
      cs_code <= seal(tx_sum_next);
    end
    else if (cs_send)
      cs_pend <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_char <= '0;
    else if (ack_send)
      tx_char <= '{valid: 1'b1, data: ack_code};
    else if (cs_send)
      tx_char <= '{valid: 1'b1, data: cs_code};
    else if (rep_take)
      tx_char <= '{valid: 1'b1, data: reply_char.data};
    else if (tx_ready)
      tx_char.valid <= 1'b0;
  end

  // Control registers; hardware mode changes win over software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_check_enable <= 1'b0;
      echo_behaviour_sel <= pcfe_pkg::ECHO_RST;
      unit_name <= pcfe_pkg::NAME_RST;
      irq_mask <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        line_check_enable <= w_data[pcfe_pkg::CTRL_CHECK];
        echo_behaviour_sel <= w_data[pcfe_pkg::CTRL_ECHO_LSB +: 2];
      end
      if (wr_name)
        unit_name <= w_data[7:0];
      if (wr_mask)
        irq_mask <= w_data[pcfe_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      addressed_mode_sel <= 1'b0;
    else if (lf_activate)
      addressed_mode_sel <= 1'b1;
    else if (lv_clear)
      addressed_mode_sel <= 1'b0;
    else if (wr_ctrl)
      addressed_mode_sel <= w_data[pcfe_pkg::CTRL_ADDR];
  end

  // Sticky events; a new event beats a same-cycle clear
  wire [pcfe_pkg::IRQ_W-1:0] irq_set;
  wire [pcfe_pkg::IRQ_W-1:0] irq_clr;
  assign irq_set[pcfe_pkg::IRQ_ACC] = finish && line_ok;
  assign irq_set[pcfe_pkg::IRQ_REJ] = finish && !line_ok;
  assign irq_set[pcfe_pkg::IRQ_MODE] = lf_activate || lv_clear;
  assign irq_clr = wr_stat ? w_data[pcfe_pkg::IRQ_W-1:0] : '0;
  assign irq = |(irq_stat & irq_mask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat <= '0;
    else
      irq_stat <= irq_set | (irq_stat & ~irq_clr);
  end

  // AXI4-Lite write side: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (do_wr)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_got)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pcfe_pkg::RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? pcfe_pkg::RESP_OKAY : pcfe_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= pcfe_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? pcfe_pkg::RESP_OKAY : pcfe_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// *** verilog/pcfe_sum.sv ***
// Purpose: 8-bit additive checksum accumulator
// Assumes: clear and add may come together, giving a fresh start at din
// Notes: sum_next shows the sum with din included
`timescale 1ns/1ps
`default_nettype none
module pcfe_sum (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic clear, // Restart from zero
  input wire logic add, // Add din
  input wire logic [7:0] din, // Character code
  output logic [7:0] sum, // Running sum
  output logic [7:0] sum_next // Sum plus din
);
  wire [7:0] base;
  assign base = clear ? 8'h00 : sum;
  assign sum_next = sum + din;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sum <= 8'h00;
    else if (clear || add)
      sum <= base + (add ? din : 8'h00);
  end
endmodule
`default_nettype wire
